// ==== bench/shrc_ctl_model.sv ====
// Safety controller model driving the request, switch and acknowledge pins.
// Assumes the bench calls put() and ack_edge() hierarchically on i_mclk.
`timescale 1ns/100ps
`default_nettype none
module shrc_ctl_model (
  input wire logic i_mclk,
  output logic o_homing_request,
  output logic o_homing_conn,
  output logic o_ref_switch_input,
  output logic o_ref_switch_conn,
  output logic o_ack_reset,
  output logic o_lim_request
);
  // ************************************
  // Pin levels
  // ************************************
  // Bits: 0 request, 1 request wired, 2 switch, 3 switch wired, 4 ack, 5 limit request
  logic [5:0] pins_r = 6'h0a;
  assign o_homing_request = pins_r[0];
  assign o_homing_conn = pins_r[1];
  assign o_ref_switch_input = pins_r[2];
  assign o_ref_switch_conn = pins_r[3];
  assign o_ack_reset = pins_r[4];
  assign o_lim_request = pins_r[5];

  // One pin change, held long enough for the synchroniser
  task automatic put(input int k, input logic v);
    @(posedge i_mclk);
    pins_r[k] <= v;
    repeat (8) @(posedge i_mclk);
  endtask

  // Acknowledge is a rising edge, then back low
  task automatic ack_edge();
    put(4, 1'b1);
    put(4, 1'b0);
  endtask
endmodule // shrc_ctl_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the safe homing and reset control block.
// Assumes shrc_top with classic Wishbone and the controller model beside it.
`timescale 1ns/100ps
`default_nettype none
`include "shrc_params.svh"
module tb_top;
  import shrc_pkg::*;
  `define CHK(g, e) check_val(32'(g), 32'(e))
  localparam int REQ = 0;
  localparam int CONN = 1;
  localparam int SW = 2;
  localparam int SWC = 3;
  localparam int LIM = 5;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, o_wb_dat;
  logic o_wb_ack, req, rconn, sw, swc, ack, lim;
  logic eval_err = 1'b0, dir_neg = 1'b0, ref_pulse = 1'b0, pos_step = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic f_ok, drv_en, valid, active, fatal;
  int n_fail = 0;
  int n_compared = 0;

  // ************************************
  // Clock, design and controller
  // ************************************
  initial forever #20 i_mclk = ~i_mclk;
  shrc_top u_shrc_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_homing_request(req), .i_homing_request_conn(rconn),
    .i_ref_switch_input(sw), .i_ref_switch_conn(swc), .i_ack_reset(ack),
    .i_ref_pulse(ref_pulse), .i_lim_pos_request(lim), .i_eval_error(eval_err),
    .i_axis_speed(speed), .i_axis_dir_neg(dir_neg), .i_pos_step(pos_step),
    .o_functional_ok_output(f_ok), .o_drive_enable(drv_en),
    .o_position_valid_flag(valid), .o_homing_active(active), .o_fatal(fatal));
  shrc_ctl_model u_shrc_ctl_model (.i_mclk(i_mclk), .o_homing_request(req),
    .o_homing_conn(rconn), .o_ref_switch_input(sw), .o_ref_switch_conn(swc),
    .o_ack_reset(ack), .o_lim_request(lim));

  // ************************************
  // Shared tasks
  // ************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rdat = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb_cycle(1'b0, a, 32'h0);
    `CHK(rdat & m, e);
  endtask

  task automatic settle();
    repeat (8) @(posedge i_mclk);
  endtask

  // Encoder steps, then one reference pulse held for the synchroniser
  task automatic step_pulse(input int n);
    repeat (n) begin
      @(posedge i_mclk) pos_step <= 1'b1;
      @(posedge i_mclk) pos_step <= 1'b0;
    end
    @(posedge i_mclk) ref_pulse <= 1'b1;
    repeat (8) @(posedge i_mclk);
    ref_pulse <= 1'b0;
    repeat (8) @(posedge i_mclk);
  endtask

  task automatic rst_dut();
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    settle();
  endtask

  // ************************************
  // Watchdog
  // ************************************
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    end_sim();
  end

  // ************************************
  // Scenarios
  // ************************************
  initial begin
    rst_dut();
    `CHK({f_ok, drv_en, valid, fatal}, 4'h0);
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h0);
    wb_cycle(1'b1, `SHRC_ADR_TRIG_SPD, 32'h0000_0010);
    rd_chk(`SHRC_ADR_TRIG_SPD, 32'hffff, 32'h0010);
    rd_chk(8'h40, 32'hffff_ffff, 32'h0);
    wb_cycle(1'b1, `SHRC_ADR_STATUS, 32'hff);
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h0);
    u_shrc_ctl_model.ack_edge();
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h1);
    `CHK({f_ok, drv_en}, 2'h3);
    // Unwired request keeps homing off
    u_shrc_ctl_model.put(CONN, 1'b0);
    u_shrc_ctl_model.put(REQ, 1'b1);
    `CHK({active, valid}, 2'h0);
    u_shrc_ctl_model.put(REQ, 1'b0);
    u_shrc_ctl_model.put(CONN, 1'b1);
    // Direct mode homes at once; falling request leaves it done
    u_shrc_ctl_model.put(REQ, 1'b1);
    `CHK(valid, 1'b1);
    u_shrc_ctl_model.put(REQ, 1'b0);
    `CHK(valid, 1'b1);
    // Switch mode: wrong direction and high speed are ignored
    wb_cycle(1'b1, `SHRC_ADR_CTRL, 32'h1);
    u_shrc_ctl_model.put(REQ, 1'b1);
    `CHK(active, 1'b1);
    @(posedge i_mclk) dir_neg <= 1'b1;
    u_shrc_ctl_model.put(SW, 1'b1);
    `CHK(active, 1'b1);
    u_shrc_ctl_model.put(SW, 1'b0);
    @(posedge i_mclk) begin
      dir_neg <= 1'b0;
      speed <= 16'h0020;
    end
    u_shrc_ctl_model.put(SW, 1'b1);
    `CHK(active, 1'b1);
    u_shrc_ctl_model.put(SW, 1'b0);
    @(posedge i_mclk) speed <= 16'h0010;
    u_shrc_ctl_model.put(SW, 1'b1);
    `CHK({active, valid}, 2'h1);
    // Abort of a run in progress
    u_shrc_ctl_model.put(REQ, 1'b0);
    u_shrc_ctl_model.put(SW, 1'b0);
    u_shrc_ctl_model.put(REQ, 1'b1);
    `CHK(active, 1'b1);
    u_shrc_ctl_model.put(REQ, 1'b0);
    `CHK(active, 1'b0);
    rd_chk(`SHRC_ADR_STATUS, 32'hc, 32'h0);
    // Limit request without homing done
    u_shrc_ctl_model.put(LIM, 1'b1);
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h2);
    `CHK({f_ok, drv_en}, 2'h0);
    u_shrc_ctl_model.put(LIM, 1'b0);
    u_shrc_ctl_model.ack_edge();
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h1);
    // Evaluation error during a run
    u_shrc_ctl_model.put(REQ, 1'b1);
    @(posedge i_mclk) eval_err <= 1'b1;
    settle();
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h2);
    `CHK(drv_en, 1'b0);
    @(posedge i_mclk) eval_err <= 1'b0;
    u_shrc_ctl_model.put(REQ, 1'b0);
    u_shrc_ctl_model.ack_edge();
    // One microsecond supervision runs out
    wb_cycle(1'b1, `SHRC_ADR_MON_TIME, 32'h1);
    u_shrc_ctl_model.put(REQ, 1'b1);
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h1);
    repeat (40) @(posedge i_mclk);
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h2);
    u_shrc_ctl_model.put(REQ, 1'b0);
    u_shrc_ctl_model.ack_edge();
    // Switch mode with unwired switch locks up
    u_shrc_ctl_model.put(SWC, 1'b0);
    `CHK(fatal, 1'b1);
    u_shrc_ctl_model.ack_edge();
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h3);
    u_shrc_ctl_model.put(SWC, 1'b1);
    rst_dut();
    // Limit nesting
    wb_cycle(1'b1, `SHRC_ADR_LIM_WIN, 32'h0010_fff0);
    settle();
    `CHK(fatal, 1'b0);
    wb_cycle(1'b1, `SHRC_ADR_LIM_POS, 32'h0020_0000);
    settle();
    `CHK(fatal, 1'b1);
    u_shrc_ctl_model.ack_edge();
    `CHK(fatal, 1'b1);
    rst_dut();
    // Automatic startup acknowledge
    wb_cycle(1'b1, `SHRC_ADR_CTRL, 32'h20);
    settle();
    rd_chk(`SHRC_ADR_STATUS, 32'h3, 32'h1);
    // Reference pulse blocked over a share of one reference unit after the switch
    wb_cycle(1'b1, `SHRC_ADR_CTRL, 32'h31);
    wb_cycle(1'b1, `SHRC_ADR_BLOCK, 32'h1);
    @(posedge i_mclk) speed <= 16'h0000;
    u_shrc_ctl_model.put(REQ, 1'b1);
    u_shrc_ctl_model.put(SW, 1'b1);
    step_pulse(`SHRC_REF_UNIT_INC / `SHRC_PCT_FULL - 1);
    `CHK(active, 1'b1);
    step_pulse(1);
    `CHK({active, valid}, 2'h1);
    // Offset with correction waits for a pulse, switch level ignored
    wb_cycle(1'b1, `SHRC_ADR_CTRL, 32'h33);
    u_shrc_ctl_model.put(REQ, 1'b0);
    u_shrc_ctl_model.put(REQ, 1'b1);
    `CHK(active, 1'b1);
    step_pulse(0);
    `CHK({active, valid}, 2'h1);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire

// ==== core/shrc_edge.sv ====
// Two-stage synchroniser with one-cycle edge pulses per bit.
// Assumes inputs asynchronous to i_mclk.
`timescale 1ns/100ps
`default_nettype none
module shrc_edge #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // Synchroniser and previous-cycle copy
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Compare consecutive cycles
  assign o_level = sync_r;
  assign o_rise = sync_r & ~prev_r;
  assign o_fall = ~sync_r & prev_r;
endmodule // shrc_edge
`default_nettype wire

// ==== core/shrc_params.svh ====
// Constants for the safe homing and reset control block.
// Assumes inclusion by bare name from files under core/.
`ifndef SHRC_PARAMS_SVH
`define SHRC_PARAMS_SVH

// ************************************
// Register offsets
// ************************************
`define SHRC_ADR_CTRL 8'h00
`define SHRC_ADR_LIM_WIN 8'h04
`define SHRC_ADR_LIM_POS 8'h08
`define SHRC_ADR_TRIG_SPD 8'h0c
`define SHRC_ADR_MON_TIME 8'h10
`define SHRC_ADR_BLOCK 8'h14
`define SHRC_ADR_STATUS 8'h18

// ************************************
// Control field positions
// ************************************
`define SHRC_CTRL_MODE_LO 0
`define SHRC_CTRL_EDGE_NEG 2
`define SHRC_CTRL_DIR_NEG 3
`define SHRC_CTRL_PULSE_USED 4
`define SHRC_CTRL_AUTO_ACK 5
`define SHRC_CTRL_RESET 32'h0000_0000

// ************************************
// Timing
// ************************************
`define SHRC_CLK_HZ 25000000
`define SHRC_US_NS 1000
`define SHRC_US_CYC ((`SHRC_US_NS * (`SHRC_CLK_HZ / 1000000)) / 1000)
`define SHRC_REF_UNIT_INC 4096
`define SHRC_PCT_FULL 100

`endif

// ==== core/shrc_pkg.sv ====
// Types for the safe homing and reset control block.
// Assumes shrc_params.svh for constants.
package shrc_pkg;

  // Module states
  typedef enum logic [1:0] {ST_INIT, ST_OPER, ST_FFS, ST_FATAL} shrc_state_t;

  // Homing run states
  typedef enum logic [1:0] {HM_IDLE, HM_RUN, HM_DONE} shrc_hstate_t;

  // Homing modes, in register encoding order
  typedef enum logic [1:0] {
    HMODE_DIRECT, HMODE_REFSW, HMODE_OFFSET, HMODE_OFFSET_CORR
  } shrc_hmode_t;

  // Pins from the safety controller plus the encoder reference pulse, synchronised together
  typedef struct packed {
    logic homing_request;
    logic homing_conn;
    logic ref_switch_input;
    logic ref_switch_conn;
    logic ack_reset;
    logic ref_pulse;
    logic lim_request;
  } shrc_pins_t;

  // Configuration held in registers
  typedef struct packed {
    shrc_hmode_t mode;
    logic edge_neg;
    logic dir_neg;
    logic pulse_used;
    logic auto_ack;
    logic signed [15:0] win_neg;
    logic signed [15:0] win_pos;
    logic signed [15:0] lim_neg;
    logic signed [15:0] lim_pos;
    logic [15:0] trig_speed;
    logic [19:0] mon_time_us;
    logic [6:0] block_pct;
  } shrc_cfg_t;

endpackage

// ==== core/shrc_top.sv ====
// Safe homing, limited-position supervision and fail-safe acknowledge.
// Assumes a classic Wishbone master on i_mclk and an evaluation unit on
// the same clock delivering speed, direction, steps and error.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "shrc_params.svh"
module shrc_top
  import shrc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_homing_request,
  input wire logic i_homing_request_conn,
  input wire logic i_ref_switch_input,
  input wire logic i_ref_switch_conn,
  input wire logic i_ack_reset,
  input wire logic i_ref_pulse,
  input wire logic i_lim_pos_request,
  input wire logic i_eval_error,
  input wire logic [15:0] i_axis_speed,
  input wire logic i_axis_dir_neg,
  input wire logic i_pos_step,
  output logic o_functional_ok_output,
  output logic o_drive_enable,
  output logic o_position_valid_flag,
  output logic o_homing_active,
  output logic o_fatal
);

  // ************************************
  // Declarations
  // ************************************
  shrc_state_t st_r, st_nxt;
  shrc_hstate_t hs_r, hs_nxt;
  shrc_cfg_t cfg_r;
  shrc_pins_t pins_async, lvl, rise, fall;
  logic wb_req, wb_wr;
  logic [31:0] rd_nxt;
  logic [31:0] ctrl_wr;
  logic fatal_c, ffs_c, ack_edge, order_bad, eval_ok, sw_edge, valid_c;
  logic valid_prev_r, sw_found_r, timeout_c, start_ok, run_done;
  logic [4:0] us_div_r;
  logic us_tick;
  logic [19:0] us_cnt_r;
  logic [19:0] blk_cnt_r;
  logic [19:0] blk_lim;
  logic [31:0] blk_prod;

  // ************************************
  // Pin synchronisation
  // ************************************
  assign pins_async = '{i_homing_request, i_homing_request_conn, i_ref_switch_input,
                        i_ref_switch_conn, i_ack_reset, i_ref_pulse, i_lim_pos_request};

  shrc_edge #(.W($bits(shrc_pins_t))) u_edge (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(pins_async),
    .o_level(lvl),
    .o_rise(rise),
    .o_fall(fall)
  );

  // ************************************
  // Wishbone slave
  // ************************************
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr = wb_req && i_wb_we;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // Control word with the write lanes merged in
  assign ctrl_wr = merge({26'h0, cfg_r.auto_ack, cfg_r.pulse_used, cfg_r.dir_neg,
                          cfg_r.edge_neg, cfg_r.mode}, i_wb_dat, i_wb_sel);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_wb_ack <= 1'b0;
    else o_wb_ack <= wb_req;
  end

  // Configuration registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg_r <= '0;
    end else if (wb_wr) begin
      case (i_wb_adr)
        `SHRC_ADR_CTRL: begin
          cfg_r.mode <= shrc_hmode_t'(ctrl_wr[`SHRC_CTRL_MODE_LO +: 2]);
          cfg_r.edge_neg <= ctrl_wr[`SHRC_CTRL_EDGE_NEG];
          cfg_r.dir_neg <= ctrl_wr[`SHRC_CTRL_DIR_NEG];
          cfg_r.pulse_used <= ctrl_wr[`SHRC_CTRL_PULSE_USED];
          cfg_r.auto_ack <= ctrl_wr[`SHRC_CTRL_AUTO_ACK];
        end
        `SHRC_ADR_LIM_WIN: {cfg_r.win_pos, cfg_r.win_neg} <=
          merge({cfg_r.win_pos, cfg_r.win_neg}, i_wb_dat, i_wb_sel);
        `SHRC_ADR_LIM_POS: {cfg_r.lim_pos, cfg_r.lim_neg} <=
          merge({cfg_r.lim_pos, cfg_r.lim_neg}, i_wb_dat, i_wb_sel);
        `SHRC_ADR_TRIG_SPD: cfg_r.trig_speed <=
          16'(merge({16'h0, cfg_r.trig_speed}, i_wb_dat, i_wb_sel));
        `SHRC_ADR_MON_TIME: cfg_r.mon_time_us <=
          20'(merge({12'h0, cfg_r.mon_time_us}, i_wb_dat, i_wb_sel));
        `SHRC_ADR_BLOCK: cfg_r.block_pct <=
          7'(merge({25'h0, cfg_r.block_pct}, i_wb_dat, i_wb_sel));
        default: ;
      endcase
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    rd_nxt = 32'h0;
    case (i_wb_adr)
      `SHRC_ADR_CTRL: rd_nxt = {26'h0, cfg_r.auto_ack, cfg_r.pulse_used, cfg_r.dir_neg,
                                cfg_r.edge_neg, cfg_r.mode};
      `SHRC_ADR_LIM_WIN: rd_nxt = {cfg_r.win_pos, cfg_r.win_neg};
      `SHRC_ADR_LIM_POS: rd_nxt = {cfg_r.lim_pos, cfg_r.lim_neg};
      `SHRC_ADR_TRIG_SPD: rd_nxt = {16'h0, cfg_r.trig_speed};
      `SHRC_ADR_MON_TIME: rd_nxt = {12'h0, cfg_r.mon_time_us};
      `SHRC_ADR_BLOCK: rd_nxt = {25'h0, cfg_r.block_pct};
      `SHRC_ADR_STATUS: rd_nxt = {24'h0, sw_found_r, o_fatal, o_position_valid_flag,
                                  o_homing_active, hs_r, st_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  // Read data register
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_wb_dat <= 32'h0;
    else if (wb_req && !i_wb_we) o_wb_dat <= rd_nxt;
  end

  // ************************************
  // Condition evaluation
  // ************************************
  assign order_bad = (cfg_r.win_neg > cfg_r.lim_neg) || (cfg_r.lim_neg > cfg_r.lim_pos) ||
                     (cfg_r.lim_pos > cfg_r.win_pos);
  assign fatal_c = order_bad ||
                   (cfg_r.mode == HMODE_REFSW && !lvl.ref_switch_conn);
  assign ack_edge = rise.ack_reset;
  assign valid_c = (hs_r == HM_DONE);
  // Trigger qualification: direction and speed
  assign eval_ok = (i_axis_dir_neg == cfg_r.dir_neg) &&
                   (i_axis_speed <= cfg_r.trig_speed);
  // Wanted switch edge flips when travelling negative
  assign sw_edge = (cfg_r.edge_neg == i_axis_dir_neg) ? rise.ref_switch_input
                                                      : fall.ref_switch_input;
  assign timeout_c = (hs_r == HM_RUN) && (cfg_r.mon_time_us != 20'h0) &&
                     (us_cnt_r >= cfg_r.mon_time_us);
  assign ffs_c = (i_eval_error && (hs_r == HM_RUN || lvl.lim_request)) ||
                 (lvl.lim_request && (!valid_c || valid_c != valid_prev_r)) ||
                 timeout_c;
  assign start_ok = rise.homing_request && lvl.homing_conn;

  // ************************************
  // Module state
  // ************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_INIT: if (cfg_r.auto_ack || ack_edge) st_nxt = ST_OPER;
      ST_OPER: if (ffs_c) st_nxt = ST_FFS;
      ST_FFS: if (ack_edge) st_nxt = ST_OPER;
      ST_FATAL: st_nxt = ST_FATAL;
    endcase
    if (fatal_c) st_nxt = ST_FATAL;
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) st_r <= ST_INIT;
    else st_r <= st_nxt;
  end

  // ************************************
  // Homing sequence
  // ************************************
  assign blk_prod = 32'(cfg_r.block_pct) * 32'(`SHRC_REF_UNIT_INC) / 32'(`SHRC_PCT_FULL);
  assign blk_lim = blk_prod[19:0];

  // Completion of a run by mode
  always_comb begin
    run_done = 1'b0;
    unique case (cfg_r.mode)
      HMODE_DIRECT, HMODE_OFFSET: run_done = 1'b1;
      HMODE_REFSW: run_done = sw_found_r && (!cfg_r.pulse_used ||
                   (blk_cnt_r >= blk_lim && eval_ok && rise.ref_pulse));
      HMODE_OFFSET_CORR: run_done = !cfg_r.pulse_used || (eval_ok && rise.ref_pulse);
    endcase
  end

  // Homing state transitions
  always_comb begin
    hs_nxt = hs_r;
    unique case (hs_r)
      HM_IDLE: if (start_ok) hs_nxt = HM_RUN;
      HM_RUN: begin
        if (fall.homing_request) hs_nxt = HM_IDLE;
        else if (run_done) hs_nxt = HM_DONE;
      end
      HM_DONE: if (start_ok) hs_nxt = HM_RUN;
    endcase
    if (st_nxt != ST_OPER || st_r != ST_OPER) hs_nxt = HM_IDLE;
  end

  // Homing registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hs_r <= HM_IDLE;
      valid_prev_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      valid_prev_r <= valid_c;
    end
  end

  // Switch found flag and blocking distance counter
  always_ff @(posedge i_mclk) begin
    if (i_rst || hs_r != HM_RUN) begin
      sw_found_r <= 1'b0;
      blk_cnt_r <= 20'h0;
    end else if (!sw_found_r) begin
      if (cfg_r.mode == HMODE_REFSW && eval_ok && sw_edge) sw_found_r <= 1'b1;
    end else if (i_pos_step && blk_cnt_r < blk_lim) begin
      blk_cnt_r <= blk_cnt_r + 20'h1;
    end
  end

  // Microsecond tick, restarted with each run so the supervision time is exact
  always_ff @(posedge i_mclk) begin
    if (i_rst || us_tick || hs_r != HM_RUN) us_div_r <= 5'h0;
    else us_div_r <= us_div_r + 5'h1;
  end
  assign us_tick = (us_div_r == 5'(`SHRC_US_CYC - 1));

  always_ff @(posedge i_mclk) begin
    if (i_rst || hs_r != HM_RUN) us_cnt_r <= 20'h0;
    else if (us_tick && us_cnt_r != 20'hfffff) us_cnt_r <= us_cnt_r + 20'h1;
  end

  // ************************************
  // Outputs
  // ************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_functional_ok_output <= 1'b0;
      o_drive_enable <= 1'b0;
      o_position_valid_flag <= 1'b0;
      o_homing_active <= 1'b0;
      o_fatal <= 1'b0;
    end else begin
      o_functional_ok_output <= (st_nxt == ST_OPER);
      o_drive_enable <= (st_nxt == ST_OPER);
      o_position_valid_flag <= (hs_nxt == HM_DONE);
      o_homing_active <= (hs_nxt == HM_RUN);
      o_fatal <= (st_nxt == ST_FATAL);
    end
  end

  // ************************************
  // Assertions
  // ************************************
  property p_ffs_off;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_OPER && ffs_c && !fatal_c) |=> !o_drive_enable && !o_functional_ok_output;
  endproperty
  a_ffs_off: assert property (p_ffs_off) else $error("drive not off in fail-safe");

  property p_order;
    @(posedge i_mclk) disable iff (i_rst)
      order_bad |=> st_r == ST_FATAL ##1 st_r == ST_FATAL;
  endproperty
  a_order: assert property (p_order) else $error("limit order not locked");

  property p_sw_unconn;
    @(posedge i_mclk) disable iff (i_rst)
      (cfg_r.mode == HMODE_REFSW && !lvl.ref_switch_conn) |=> o_fatal;
  endproperty
  a_sw_unconn: assert property (p_sw_unconn) else $error("no fatal on open switch");

  property p_start;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_OPER && hs_r == HM_IDLE && start_ok && !ffs_c && !fatal_c) |=>
        hs_r != HM_IDLE;
  endproperty
  a_start: assert property (p_start) else $error("homing did not start");

  property p_abort;
    @(posedge i_mclk) disable iff (i_rst)
      (hs_r == HM_RUN && fall.homing_request) |=> hs_r == HM_IDLE && !o_homing_active;
  endproperty
  a_abort: assert property (p_abort) else $error("homing not aborted");

  property p_done_keep;
    @(posedge i_mclk) disable iff (i_rst)
      (hs_r == HM_DONE && fall.homing_request && st_r == ST_OPER && !ffs_c && !fatal_c)
        |=> hs_r == HM_DONE;
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done lost on falling edge");

  property p_unconn;
    @(posedge i_mclk) disable iff (i_rst)
      (hs_r == HM_IDLE && !lvl.homing_conn) |=> hs_r == HM_IDLE;
  endproperty
  a_unconn: assert property (p_unconn) else $error("homing ran while unconnected");

  property p_valid;
    @(posedge i_mclk) disable iff (i_rst)
      (hs_nxt != HM_DONE) |=> !o_position_valid_flag;
  endproperty
  a_valid: assert property (p_valid) else $error("position valid without homing");

  property p_ack;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_FFS && ack_edge && !fatal_c) |=> st_r == ST_OPER ##0 o_functional_ok_output;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not taken");

  property p_init;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_INIT && !cfg_r.auto_ack && !ack_edge && !fatal_c) |=> st_r == ST_INIT;
  endproperty
  a_init: assert property (p_init) else $error("left init without acknowledge");

  property p_limreq;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_OPER && lvl.lim_request && hs_r != HM_DONE && !fatal_c) |=> st_r == ST_FFS;
  endproperty
  a_limreq: assert property (p_limreq) else $error("limit request without homing");

  property p_eval;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_OPER && i_eval_error && hs_r == HM_RUN && !fatal_c) |=> st_r == ST_FFS;
  endproperty
  a_eval: assert property (p_eval) else $error("evaluation error ignored");

endmodule // shrc_top
`default_nettype wire
